// ===== rtl/flash_code_defs.vh
// constants for the alarm flash-code indicator: priorities, codes, timing
// assumes a 100 MHz clock; included by bare name from rtl design files
//
// Function
// - pulse 0.3 s lit, 0.3 s dark, 6 s window
// - pulses per window equal code, rest dark
// - second-level low: priority 6, code 4
// - first-level high 4, low 3; code 2
// - sensor trouble code: priority 2, code 1
// - sensor trouble set after 35 minutes silence
// - defaults into both copies: priority 10, code 7
// - factory over custom: priority 9, code 7
// - custom over factory: priority 8, code 7
// - low sensor battery: priority 1, code 6
// - no sensors registered: priority 5, code 3
// - software restart: priority 11, code 8
// - corrupt, no backup: restore factory, drop sensors
// - corrupt with valid backup: load backup
// - led lit during power-up
`ifndef FLASH_CODE_DEFS_VH
`define FLASH_CODE_DEFS_VH

`define CLK_HZ            100000000
`define PULSE_MS          300
`define WINDOW_MS         6000
`define TIMEOUT_MIN       35
`define POWERUP_MS        300

`define PRI_NONE          4'h0
`define PRI_BATT_LOW      4'h1
`define PRI_SENSOR_DTC    4'h2
`define PRI_FIRST_LOW     4'h3
`define PRI_FIRST_HIGH    4'h4
`define PRI_SETUP_DTC     4'h5
`define PRI_SECOND_LOW    4'h6
`define PRI_HIGH_TEMP     4'h7
`define PRI_CUST_TO_FACT  4'h8
`define PRI_FACT_TO_CUST  4'h9
`define PRI_ROM_TO_BOTH   4'ha
`define PRI_RESTART       4'hb

`define CODE_NONE         4'h0
`define CODE_SENSOR_DTC   4'h1
`define CODE_FIRST_LEVEL  4'h2
`define CODE_SETUP_DTC    4'h3
`define CODE_SECOND_LOW   4'h4
`define CODE_HIGH_TEMP    4'h5
`define CODE_BATT_LOW     4'h6
`define CODE_CONFIG_COPY  4'h7
`define CODE_RESTART      4'h8

`define NUM_COND          11

`define CFG_SRC_KEEP      2'h0
`define CFG_SRC_FACTORY   2'h1
`define CFG_SRC_BACKUP    2'h2

`endif

// ===== rtl/sync2.v
// two-flop synchroniser, one per bit of a bus
// assumes inputs may change at any time relative to i_clk
`timescale 1ns/100ps
`default_nettype none
module sync2
#(
  parameter WIDTH = 1
)
(
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire             i_ce,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // first stage feeds only the second
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end
    else if (i_ce)
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // sync2
`default_nettype wire

// ===== rtl/sensor_timeout.v
// per-sensor silence timers, one generate entry per sensor slot
// assumes sensor data strobes are single cycles on i_clk
`timescale 1ns/100ps
`include "flash_code_defs.vh"
`default_nettype none
module sensor_timeout
#(
  parameter NUM_SENSORS = 8,
  parameter TICK_CYCLES = `CLK_HZ,            // cycles per second
  parameter TIMEOUT_S   = `TIMEOUT_MIN * 60   // silence seconds before trouble
)
(
  input  wire                   i_clk,
  input  wire                   i_rst_n,
  input  wire                   i_ce,
  input  wire [NUM_SENSORS-1:0] i_registered,
  input  wire [NUM_SENSORS-1:0] i_data_rx,
  output wire                   o_timeout
);
  reg  [31:0]            tick_ff;
  wire                   tick;
  wire [NUM_SENSORS-1:0] expired;

  // one-second tick shared by all timers
  assign tick = (tick_ff == TICK_CYCLES - 1);
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tick_ff <= 32'h0;
    else if (i_ce)
      tick_ff <= tick ? 32'h0 : tick_ff + 32'h1;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SENSORS; g = g + 1)
    begin : g_slot
      reg [15:0] secs_ff;
      // counts seconds of silence; data or deregistration restarts it
      always @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          secs_ff <= 16'h0;
        else if (i_ce)
        begin
          if (!i_registered[g] || i_data_rx[g])
            secs_ff <= 16'h0;
          else if (tick && secs_ff != TIMEOUT_S[15:0])
            secs_ff <= secs_ff + 16'h1;
        end
      end
      assign expired[g] = i_registered[g] && (secs_ff == TIMEOUT_S[15:0]);
    end
  endgenerate

  assign o_timeout = |expired;
endmodule // sensor_timeout
`default_nettype wire

// ===== rtl/flash_code_indicator.v
// alarm arbitration and flash-code led driver, with config recovery events
// assumes alarm levels arrive from other logic on i_clk; sensor
// strobes and registration flags from i_clk logic; power-up via i_rst_n
`timescale 1ns/100ps
`include "flash_code_defs.vh"
`default_nettype none
module flash_code_indicator
#(
  parameter NUM_SENSORS    = 8,
  parameter PULSE_CYCLES   = (`CLK_HZ / 1000) * `PULSE_MS,
  parameter WINDOW_CYCLES  = (`CLK_HZ / 1000) * `WINDOW_MS,
  parameter POWERUP_CYCLES = (`CLK_HZ / 1000) * `POWERUP_MS,
  parameter TICK_CYCLES    = `CLK_HZ,
  parameter TIMEOUT_S      = `TIMEOUT_MIN * 60
)
(
  input  wire                   i_clk,
  input  wire                   i_rst_n,
  input  wire                   i_ce,
  input  wire                   i_second_level_low_alarm,
  input  wire                   i_first_level_high_alarm,
  input  wire                   i_first_level_low_alarm,
  input  wire                   i_high_temp_alarm,
  input  wire                   i_batt_low_alert,
  input  wire [NUM_SENSORS-1:0] i_registered,
  input  wire [NUM_SENSORS-1:0] i_data_rx,
  input  wire                   i_cfg_check,
  input  wire                   i_cfg_corrupt,
  input  wire                   i_backup_valid,
  input  wire                   i_rom_to_both,
  input  wire                   i_fact_to_cust,
  input  wire                   i_cust_to_fact,
  input  wire                   i_sw_restart,
  input  wire                   i_event_clear,
  output reg                    o_diagnostic_led_output,
  output reg  [1:0]             o_cfg_restore,
  output reg                    o_restore_strobe,
  output reg  [3:0]             o_active_priority,
  output reg  [3:0]             o_active_code
);
  //////////////////////////////////////////////////////////////////////////
  // state of the pulse sequencer
  localparam ST_POWERUP = 2'b00;
  localparam ST_LIT     = 2'b01;
  localparam ST_DARK    = 2'b10;
  localparam ST_IDLE    = 2'b11;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [31:0] phase_ff;     // cycles within current pulse phase
  reg  [31:0] nxt_phase;
  reg  [31:0] window_ff;    // cycles within the repeating window
  reg  [31:0] nxt_window;
  reg  [3:0]  pulses_ff;    // lit pulses emitted in this window
  reg  [3:0]  nxt_pulses;
  reg  [3:0]  code_ff;      // code latched at the window start
  reg  [3:0]  nxt_code;
  reg         nxt_led;

  // sticky event flags, restart edge detect and restore decodes
  reg         rom_both_ff;
  reg         fact_cust_ff;
  reg         cust_fact_ff;
  reg         restart_ff;
  reg         restart_seen_ff;
  reg         fact_restore_ev;
  reg         backup_restore_ev;

  wire        sensor_dtc;
  wire        setup_dtc;
  reg  [3:0]  win_pri;
  reg  [3:0]  win_code;
  wire        sw_restart_s;

  //////////////////////////////////////////////////////////////////////////
  // restart cause flag is a pin from the supervisor, so synchronise it
  sync2 #(.WIDTH(1)) u_restart_sync
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (i_sw_restart),
    .o_sync  (sw_restart_s)
  );

  // silence timers over all registered sensors
  sensor_timeout #(
    .NUM_SENSORS (NUM_SENSORS),
    .TICK_CYCLES (TICK_CYCLES),
    .TIMEOUT_S   (TIMEOUT_S)
  ) u_timeout
  (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_ce         (i_ce),
    .i_registered (i_registered),
    .i_data_rx    (i_data_rx),
    .o_timeout    (sensor_dtc)
  );

  // setup code holds while no sensor is registered
  assign setup_dtc = ~(|i_registered);

  //////////////////////////////////////////////////////////////////////////
  // configuration check: decide recovery source
  always @*
  begin
    fact_restore_ev   = i_cfg_check && i_cfg_corrupt && !i_backup_valid;
    backup_restore_ev = i_cfg_check && i_cfg_corrupt && i_backup_valid;
  end

  // restore command to the config store; factory wipes sensors and settings
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cfg_restore    <= `CFG_SRC_KEEP;
      o_restore_strobe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_restore_strobe <= fact_restore_ev | backup_restore_ev;
      if (fact_restore_ev)
        o_cfg_restore <= `CFG_SRC_FACTORY;
      else if (backup_restore_ev)
        o_cfg_restore <= `CFG_SRC_BACKUP;
    end
  end

  // sticky event flags; a new event wins over a clear in the same cycle
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rom_both_ff     <= 1'b0;
      fact_cust_ff    <= 1'b0;
      cust_fact_ff    <= 1'b0;
      restart_ff      <= 1'b0;
      restart_seen_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      rom_both_ff     <= i_rom_to_both | fact_restore_ev | (rom_both_ff & ~i_event_clear);
      fact_cust_ff    <= i_fact_to_cust | (fact_cust_ff & ~i_event_clear);
      cust_fact_ff    <= i_cust_to_fact | backup_restore_ev
                         | (cust_fact_ff & ~i_event_clear);
      restart_seen_ff <= sw_restart_s;
      restart_ff      <= (sw_restart_s & ~restart_seen_ff)
                         | (restart_ff & ~i_event_clear);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // priority arbitration: highest active condition wins
  always @*
  begin
    win_pri  = `PRI_NONE;
    win_code = `CODE_NONE;
    if (restart_ff)
    begin
      win_pri  = `PRI_RESTART;
      win_code = `CODE_RESTART;
    end
    else if (rom_both_ff)
    begin
      win_pri  = `PRI_ROM_TO_BOTH;
      win_code = `CODE_CONFIG_COPY;
    end
    else if (fact_cust_ff)
    begin
      win_pri  = `PRI_FACT_TO_CUST;
      win_code = `CODE_CONFIG_COPY;
    end
    else if (cust_fact_ff)
    begin
      win_pri  = `PRI_CUST_TO_FACT;
      win_code = `CODE_CONFIG_COPY;
    end
    else if (i_high_temp_alarm)
    begin
      win_pri  = `PRI_HIGH_TEMP;
      win_code = `CODE_HIGH_TEMP;
    end
    else if (i_second_level_low_alarm)
    begin
      win_pri  = `PRI_SECOND_LOW;
      win_code = `CODE_SECOND_LOW;
    end
    else if (setup_dtc)
    begin
      win_pri  = `PRI_SETUP_DTC;
      win_code = `CODE_SETUP_DTC;
    end
    else if (i_first_level_high_alarm)
    begin
      win_pri  = `PRI_FIRST_HIGH;
      win_code = `CODE_FIRST_LEVEL;
    end
    else if (i_first_level_low_alarm)
    begin
      win_pri  = `PRI_FIRST_LOW;
      win_code = `CODE_FIRST_LEVEL;
    end
    else if (sensor_dtc)
    begin
      win_pri  = `PRI_SENSOR_DTC;
      win_code = `CODE_SENSOR_DTC;
    end
    else if (i_batt_low_alert)
    begin
      win_pri  = `PRI_BATT_LOW;
      win_code = `CODE_BATT_LOW;
    end
  end

  // registered view of the arbitration result
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_active_priority <= `PRI_NONE;
      o_active_code     <= `CODE_NONE;
    end
    else if (i_ce)
    begin
      o_active_priority <= win_pri;
      o_active_code     <= win_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pulse sequencer next state
  always @*
  begin
    nxt_state  = state_ff;
    nxt_phase  = phase_ff + 32'h1;
    nxt_window = window_ff + 32'h1;
    nxt_pulses = pulses_ff;
    nxt_code   = code_ff;
    nxt_led    = 1'b0;
    if (window_ff == WINDOW_CYCLES - 1)
    begin
      // window restarts: latch the current winner
      nxt_window = 32'h0;
      nxt_phase  = 32'h0;
      nxt_pulses = 4'h0;
      nxt_code   = win_code;
      nxt_state  = (win_code == `CODE_NONE) ? ST_IDLE : ST_LIT;
      nxt_led    = (win_code != `CODE_NONE);
    end
    else
    begin
      case (state_ff)
        ST_POWERUP:
        begin
          nxt_led = 1'b1;
          if (phase_ff == POWERUP_CYCLES - 1)
          begin
            nxt_led    = 1'b0;
            nxt_state  = ST_IDLE;
            nxt_window = WINDOW_CYCLES - 1;
          end
        end
        ST_LIT:
        begin
          nxt_led = 1'b1;
          if (phase_ff == PULSE_CYCLES - 1)
          begin
            nxt_led    = 1'b0;
            nxt_phase  = 32'h0;
            nxt_pulses = pulses_ff + 4'h1;
            nxt_state  = ST_DARK;
          end
        end
        ST_DARK:
        begin
          if (phase_ff == PULSE_CYCLES - 1)
          begin
            nxt_phase = 32'h0;
            if (pulses_ff < code_ff)
            begin
              nxt_state = ST_LIT;
              nxt_led   = 1'b1;
            end
            else
              nxt_state = ST_IDLE;
          end
        end
        ST_IDLE:
          nxt_phase = 32'h0;
        default:
          nxt_state = ST_IDLE;
      endcase
    end
  end

  // pulse sequencer registers; led lit from reset for power-up check
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff                <= ST_POWERUP;
      phase_ff                <= 32'h0;
      window_ff               <= 32'h0;
      pulses_ff               <= 4'h0;
      code_ff                 <= `CODE_NONE;
      o_diagnostic_led_output <= 1'b1;
    end
    else if (i_ce)
    begin
      state_ff                <= nxt_state;
      phase_ff                <= nxt_phase;
      window_ff               <= (state_ff == ST_POWERUP && nxt_state == ST_POWERUP)
                                 ? 32'h0 : nxt_window;
      pulses_ff               <= nxt_pulses;
      code_ff                 <= nxt_code;
      o_diagnostic_led_output <= nxt_led;
    end
  end
endmodule // flash_code_indicator
`default_nettype wire

// ===== bench/alarm_flash_sva.sv
// port checker for the flash-code indicator
// assumes it is bound onto flash_code_indicator, one clock domain
`timescale 1ns/100ps
`default_nettype none
module alarm_flash_sva
#(
  parameter NUM_SENSORS  = 8,
  parameter PULSE_CYCLES = 2
)
(
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  input wire logic                   i_ce,
  input wire logic                   i_second_level_low_alarm,
  input wire logic                   i_high_temp_alarm,
  input wire logic                   i_batt_low_alert,
  input wire logic [NUM_SENSORS-1:0] i_registered,
  input wire logic                   i_cfg_check,
  input wire logic                   i_cfg_corrupt,
  input wire logic                   i_backup_valid,
  input wire logic                   o_diagnostic_led_output,
  input wire logic [1:0]             o_cfg_restore,
  input wire logic                   o_restore_strobe,
  input wire logic [3:0]             o_active_priority,
  input wire logic [3:0]             o_active_code
);
  logic [7:0] lit_ff;
  logic       dark_seen_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  // lit run length in enabled cycles, and whether the power-up glow has ended
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lit_ff       <= 8'h00;
      dark_seen_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      lit_ff       <= o_diagnostic_led_output ? lit_ff + 8'h01 : 8'h00;
      dark_seen_ff <= dark_seen_ff | !o_diagnostic_led_output;
    end
  end
  a_powerup_lit: assert property ($rose(i_rst_n) |-> o_diagnostic_led_output)
    else $error("led dark at reset release");
  a_pulse_width: assert property ($fell(o_diagnostic_led_output) && dark_seen_ff
    |-> lit_ff == PULSE_CYCLES) else $error("lit pulse of wrong length");
  a_factory_restore: assert property (i_ce && i_cfg_check && i_cfg_corrupt
    && !i_backup_valid |=> o_restore_strobe && o_cfg_restore == 2'h1)
    else $error("factory restore missing");
  a_backup_restore: assert property (i_ce && i_cfg_check && i_cfg_corrupt
    && i_backup_valid |=> o_restore_strobe && o_cfg_restore == 2'h2)
    else $error("backup restore missing");
  a_strobe_cause: assert property (o_restore_strobe
    |-> $past(i_ce && i_cfg_check && i_cfg_corrupt)) else $error("stray restore strobe");
  a_setup_shown: assert property (i_ce && i_registered == '0
    |=> o_active_priority >= 4'h5) else $error("setup code hidden");
  a_temp_wins: assert property (i_ce && i_high_temp_alarm |=> o_active_priority >= 4'h7
    && (o_active_priority != 4'h7 || o_active_code == 4'h5)) else $error("temperature lost");
  a_sal_code: assert property (o_active_priority == 4'h6
    |-> o_active_code == 4'h4 && $past(i_second_level_low_alarm)) else $error("sal code");
  a_batt_code: assert property (o_active_priority == 4'h1
    |-> o_active_code == 4'h6 && $past(i_batt_low_alert)) else $error("battery code");
  a_fixed_codes: assert property (o_active_priority inside {4'h3, 4'h4}
    |-> o_active_code == 4'h2) else $error("first level code");
  a_copy_code: assert property (o_active_priority inside {4'h8, 4'h9, 4'ha}
    |-> o_active_code == 4'h7) else $error("copy event code");
  a_restart_code: assert property (o_active_priority == 4'hb |-> o_active_code == 4'h8)
    else $error("restart code");
  a_sensor_code: assert property (o_active_priority == 4'h2 |-> o_active_code == 4'h1)
    else $error("sensor code");
endmodule // alarm_flash_sva
`default_nettype wire

// ===== bench/led_observer.sv
// led watcher: pulse count per window and window period
// assumes led sampled on the indicator clock, high means lit
`timescale 1ns/100ps
`default_nettype none
module led_observer
#(
  parameter PULSE  = 2,
  parameter WINDOW = 40
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_led,
  output var  logic [3:0] o_code,
  output var  logic [7:0] o_period
);
  logic [7:0] run_ff;
  logic [7:0] since_ff;
  logic [3:0] cnt_ff;
  logic       prev_ff;
  ////////////////////////////////////////
  // count rises, latch count on long dark, time first rises
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {run_ff, since_ff, cnt_ff, o_code, o_period} <= '0;
      prev_ff <= 1'b1;
    end
    else
    begin
      prev_ff  <= i_led;
      run_ff   <= (i_led == prev_ff) ? run_ff + 8'h01 : 8'h01;
      since_ff <= since_ff + 8'h01;
      if (i_led && !prev_ff)
      begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff == 4'h0)
        begin
          o_period <= since_ff;
          since_ff <= 8'h01;
        end
      end
      // a whole dark window also ends a count, so code 0 reads back as 0
      if (!i_led && (run_ff == 2 * PULSE || run_ff == WINDOW))
      begin
        o_code <= cnt_ff;
        cnt_ff <= 4'h0;
      end
    end
  end
endmodule // led_observer
`default_nettype wire

// ===== bench/alarm_flash_code_indicator_bench.sv
// self-checking bench for the flash-code indicator
// assumes shortened timing parameters; checker bound at the foot
`timescale 1ns/100ps
`default_nettype none
module alarm_flash_code_indicator_bench;
  localparam int WINDOW = 40;
  logic       i_clk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       ce = 1'b1;
  logic [4:0] alm = '0;      // second low, first high, first low, temp, battery
  logic [7:0] reg_s = 8'hff;
  logic [7:0] rx = '0;
  logic       feed = 1'b1;
  logic [4:0] ctl = '0;      // check, corrupt, backup, clear, restart
  logic [2:0] ev = '0;       // defaults copy, factory to custom, custom to factory
  wire        led;
  wire  [1:0] restore;
  wire        strobe;
  wire  [3:0] pri;
  wire  [3:0] code;
  wire  [3:0] obs_code;
  wire  [7:0] obs_per;
  int         mismatches = 0;
  int         compares = 0;
  ////////////////////////////////////////
  // clock and sensor data strobes every other cycle
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) rx <= #1 (feed && rx == 8'h00) ? 8'hff : 8'h00;
  flash_code_indicator
  #(.PULSE_CYCLES(2), .WINDOW_CYCLES(WINDOW), .POWERUP_CYCLES(2), .TICK_CYCLES(2), .TIMEOUT_S(3))
  u_flash_code_indicator
  (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_second_level_low_alarm(alm[4]),
    .i_first_level_high_alarm(alm[3]), .i_first_level_low_alarm(alm[2]),
    .i_high_temp_alarm(alm[1]), .i_batt_low_alert(alm[0]), .i_registered(reg_s),
    .i_data_rx(rx), .i_cfg_check(ctl[4]), .i_cfg_corrupt(ctl[3]), .i_backup_valid(ctl[2]),
    .i_rom_to_both(ev[2]), .i_fact_to_cust(ev[1]), .i_cust_to_fact(ev[0]),
    .i_sw_restart(ctl[0]), .i_event_clear(ctl[1]), .o_diagnostic_led_output(led),
    .o_cfg_restore(restore), .o_restore_strobe(strobe), .o_active_priority(pri),
    .o_active_code(code)
  );
  led_observer #(.PULSE(2), .WINDOW(WINDOW)) u_led_observer
    (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_led(led), .o_code(obs_code), .o_period(obs_per));
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic see(input logic [3:0] p, input logic [3:0] c);
    chk({4'h0, pri}, {4'h0, p});
    chk({4'h0, code}, {4'h0, c});
  endtask
  task automatic window(input logic [3:0] c);
    tick(3 * WINDOW);
    chk({4'h0, obs_code}, {4'h0, c});
    if (c != 4'h0)
      chk(obs_per, 8'(WINDOW));
  endtask
  task automatic clear;
    ctl = 5'h02;
    tick(1);
    ctl = '0;
    tick(2);
    see(4'h0, 4'h0);
  endtask
  task automatic do_reset;
    i_rst_n = 1'b0;
    tick(3);
    chk({7'h0, led}, 8'h01);
    i_rst_n = 1'b1;
    tick(1);
    chk({7'h0, led}, 8'h01);
  endtask
  task automatic t_alarms;
    logic [3:0] p [5] = '{4'h6, 4'h4, 4'h3, 4'h7, 4'h1};
    logic [3:0] c [5] = '{4'h4, 4'h2, 4'h2, 4'h5, 4'h6};
    for (int k = 0; k < 5; k++)
    begin
      alm = 5'h10 >> k;
      tick(2);
      see(p[k], c[k]);
      window(c[k]);
    end
    alm = '0;
    tick(2);
    window(4'h0);
  endtask
  task automatic t_priority;
    logic [4:0] a [5] = '{5'h1f, 5'h1d, 5'h0d, 5'h05, 5'h01};
    logic [3:0] p [5] = '{4'h7, 4'h6, 4'h4, 4'h3, 4'h1};
    for (int k = 0; k < 5; k++)
    begin
      alm = a[k];
      tick(2);
      chk({4'h0, pri}, {4'h0, p[k]});
    end
    alm = '0;
  endtask
  task automatic cfg(input logic bk, input logic [1:0] src, input logic [3:0] p);
    ctl = {2'b11, bk, 2'b00};
    tick(1);
    ctl = '0;
    chk({7'h0, strobe}, 8'h01);
    chk({6'h0, restore}, {6'h0, src});
    tick(2);
    see(p, 4'h7);
    clear;
  endtask
  task automatic t_events;
    for (int k = 0; k < 3; k++)
    begin
      ev = 3'b100 >> k;
      ctl = 5'h02;
      tick(1);
      ev = '0;
      ctl = '0;
      tick(2);
      see(4'ha - 4'(k), 4'h7);
      clear;
    end
    ctl = 5'h01;
    for (int n = 0; n < 8 && pri !== 4'hb; n++)
      tick(1);
    see(4'hb, 4'h8);
    window(4'h8);
    ctl = '0;
    tick(1);
    clear;
  endtask
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    do_reset;
    tick(4);
    see(4'h0, 4'h0);
    reg_s = 8'h00;
    tick(2);
    see(4'h5, 4'h3);
    window(4'h3);
    reg_s = 8'hff;
    t_alarms;
    t_priority;
    tick(2);
    see(4'h0, 4'h0);
    ce = 1'b0;
    alm = 5'h02;
    tick(3);
    see(4'h0, 4'h0);
    ce = 1'b1;
    tick(2);
    see(4'h7, 4'h5);
    alm = '0;
    reg_s = 8'h01;
    feed = 1'b0;
    tick(3);
    see(4'h0, 4'h0);
    tick(10);
    see(4'h2, 4'h1);
    feed = 1'b1;
    tick(3);
    see(4'h0, 4'h0);
    reg_s = 8'hff;
    cfg(1'b0, 2'h1, 4'ha);
    cfg(1'b1, 2'h2, 4'h8);
    ctl = 5'h10;
    tick(1);
    ctl = '0;
    chk({7'h0, strobe}, 8'h00);
    t_events;
    do_reset;
    end_of_test;
  end
endmodule // alarm_flash_code_indicator_bench
bind flash_code_indicator alarm_flash_sva #(.NUM_SENSORS(NUM_SENSORS), .PULSE_CYCLES(PULSE_CYCLES))
  u_alarm_flash_sva
  (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_high_temp_alarm(i_high_temp_alarm),
    .i_second_level_low_alarm(i_second_level_low_alarm), .i_batt_low_alert(i_batt_low_alert),
    .i_registered(i_registered), .i_cfg_check(i_cfg_check), .i_cfg_corrupt(i_cfg_corrupt),
    .i_backup_valid(i_backup_valid), .o_diagnostic_led_output(o_diagnostic_led_output),
    .o_cfg_restore(o_cfg_restore), .o_restore_strobe(o_restore_strobe),
    .o_active_priority(o_active_priority), .o_active_code(o_active_code)
  );
`default_nettype wire
